// ---- rtm_host_model.sv ----
// Host side: line clock source and interrupt edge counter
`timescale 1ns/10ps
`default_nettype none
module rtm_host_model #(
	parameter int HALF_NS = 20
)
(
	input wire logic pci_irq_line_n,
	output logic transmit_line_clock,
	output logic [7:0] irq_edges
);
	// 25 MHz line clock of a fast link, where the host picks the divide by 20 tick
	// A transmit line clock runs free, so it is not stopped between frames
	initial
	begin
		transmit_line_clock = 1'b0;
		#3;
		forever #(HALF_NS) transmit_line_clock = ~transmit_line_clock;
	end

	// One process owns the edge count, start value included
	initial
	begin
		irq_edges = 8'h00;
		forever
		begin
			@(negedge pci_irq_line_n);
			irq_edges = irq_edges + 8'h01;
		end
	end
endmodule
`default_nettype wire

// ---- rtm_irq_mask.sv ----
// Interrupt moderation: register slave, status, masking timer and line gating
//
// What this block does
// - High priority frame skips masking when enabled
// - Tick is line clock over 20 or 2
// - Size code selects 64/128/256/512 byte limit
// - Short frame skips active masking when enabled
// - Skip off: receive held while masking
// - Mode 00 never loads the timer
// - Mode write loads period times 128
// - Timer drops by one per tick
// - Nonzero timer holds transmit and receive line
// - Mode 10 reloads after both cleared
// - Mode 11 reloads on first new interrupt
// - Reserved bit 7 reads zero
// - Load is period times 128, zero none
// - Error interrupts never held back
//
// The address map and the Avalon-MM register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module rtm_irq_mask
	import rtm_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic transmit_line_clock,
	input wire logic receive_done_irq,
	input wire logic [15:0] rx_frame_len,
	input wire logic rx_high_prio,
	input wire logic transmit_done_irq,
	input wire logic error_irq,
	output logic irq,
	output logic pci_irq_line_n
);
	logic [31:0] ctrl_q, ctrl_d;
	logic [2:0] stat_q, stat_d;
	logic [2:0] mask_q, mask_d;
	logic rx_skip_q, rx_skip_d;
	logic [RTM_TIMER_W-1:0] count_q;
	logic tick;

	// Bus decode: a write is taken at the edge where waitrequest is low, read data is captured while it is still high
	wire logic req = avs_read | avs_write;
	wire logic wr_acc = avs_write & ~avs_waitrequest;
	wire logic rd_cap = avs_read & avs_waitrequest;
	wire logic sel_ctrl = (avs_address == RTM_CTRL_OFS);
	wire logic sel_stat = (avs_address == RTM_STAT_OFS);
	wire logic sel_mask = (avs_address == RTM_MASK_OFS);
	wire logic sel_count = (avs_address == RTM_COUNT_OFS);
	wire logic [31:0] lane_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
		{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	wire logic [31:0] wmask = lane_mask & RTM_CTRL_WR_MASK;
	wire logic wr_ctrl = wr_acc & sel_ctrl;
	wire logic wr_stat = wr_acc & sel_stat;
	wire logic wr_mask = wr_acc & sel_mask;

	// Control fields
	wire logic hp_skip = ctrl_q[RTM_HP_SKIP_BIT];
	wire logic tick_scale_by_ten = ctrl_q[RTM_SCALE_BIT];
	wire logic [1:0] short_frame_size_select = ctrl_q[RTM_SIZE_LSB +: 2];
	wire logic short_frame_skip = ctrl_q[RTM_SHORT_SKIP_BIT];
	wire rtm_mode_type masking_mode_field = rtm_mode_type'(ctrl_q[RTM_MODE_LSB +: 2]);
	wire logic [RTM_PERIOD_W-1:0] masking_period_field = ctrl_q[RTM_PERIOD_LSB +: RTM_PERIOD_W];
	wire logic [RTM_TIMER_W-1:0] load_value =
		RTM_TIMER_W'(masking_period_field) * RTM_TIMER_W'(RTM_PERIOD_MULT);
	wire logic timer_active = (count_q != '0);

	// Short frame classification
	wire logic is_short = (rx_frame_len <= RTM_SHORT_LIMIT[short_frame_size_select]);

	// Status: a new event wins over a same-cycle clear
	wire logic [2:0] clr = wr_stat ? (avs_writedata[2:0] & lane_mask[2:0]) : 3'h0;
	wire logic [2:0] set_ev = {error_irq, transmit_done_irq, receive_done_irq};
	wire logic [1:0] done_now = stat_q[RTM_ST_TX:RTM_ST_RX];
	wire logic [1:0] done_next = stat_d[RTM_ST_TX:RTM_ST_RX];

	// Receive bypass marking, held until the receive status is cleared
	wire logic hp_hit = receive_done_irq & rx_high_prio & hp_skip;
	wire logic short_hit = receive_done_irq & is_short & short_frame_skip & timer_active;

	// Timer load sources
	wire logic mode_write = wr_ctrl & avs_byteenable[0] &
		(avs_writedata[RTM_MODE_LSB +: 2] != 2'b00);
	wire logic [RTM_PERIOD_W-1:0] new_period = ctrl_d[RTM_PERIOD_LSB +: RTM_PERIOD_W];
	wire logic both_cleared = wr_stat & (done_now != 2'b00) & (done_next == 2'b00);
	wire logic auto_on_clear = (masking_mode_field == RTM_MODE_ON_CLEAR) & both_cleared;
	wire logic first_new = (done_now == 2'b00) & (done_next != 2'b00);
	wire logic auto_on_event = (masking_mode_field == RTM_MODE_ON_EVENT) & first_new;
	wire logic timer_load = mode_write | auto_on_clear | auto_on_event;
	wire logic [RTM_TIMER_W-1:0] timer_value = mode_write ?
		RTM_TIMER_W'(new_period) * RTM_TIMER_W'(RTM_PERIOD_MULT) : load_value;

	// Line gating: masking acts only on the line, never on the status bits
	wire logic [2:0] pend = stat_q & mask_q;
	wire logic rx_pass = pend[RTM_ST_RX] & (~timer_active | rx_skip_q);
	wire logic tx_pass = pend[RTM_ST_TX] & ~timer_active;
	wire logic err_pass = pend[RTM_ST_ERR];
	wire logic irq_d = rx_pass | tx_pass | err_pass;

	// Read mux; bit 7 and unused bits are never stored, unmapped reads give zero
	wire logic [31:0] rd_mux = sel_ctrl ? (ctrl_q & RTM_CTRL_WR_MASK) :
		sel_stat ? {29'h0, stat_q} :
		sel_mask ? {29'h0, mask_q} :
		sel_count ? {20'h0, count_q} : 32'h0000_0000;

	always_comb
	begin
		ctrl_d = ctrl_q;
		if (wr_ctrl)
			ctrl_d = (ctrl_q & ~wmask) | (avs_writedata & wmask);
		mask_d = mask_q;
		if (wr_mask)
			mask_d = (mask_q & ~lane_mask[2:0]) | (avs_writedata[2:0] & lane_mask[2:0]);
		stat_d = (stat_q & ~clr) | set_ev;
		rx_skip_d = rx_skip_q;
		if (clr[RTM_ST_RX])
			rx_skip_d = 1'b0;
		if (hp_hit | short_hit)
			rx_skip_d = 1'b1;
	end

	rtm_tick_gen u_tick
	(
		.clk_sys(clk_sys),
		.srst(srst),
		.transmit_line_clock(transmit_line_clock),
		.tick_scale_by_ten(tick_scale_by_ten),
		.tick_q(tick)
	);

	rtm_mask_timer #(.W(RTM_TIMER_W)) u_timer
	(
		.clk_sys(clk_sys),
		.srst(srst),
		.load(timer_load),
		.load_value(timer_value),
		.tick(tick),
		.count_q(count_q)
	);

	always_ff @(posedge clk_sys)
	begin
		if (srst)
		begin
			ctrl_q <= RTM_CTRL_RESET;
			stat_q <= RTM_STAT_RESET;
			mask_q <= RTM_MASK_RESET;
			rx_skip_q <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
			irq <= 1'b0;
			pci_irq_line_n <= 1'b1;
		end
		else
		begin
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			rx_skip_q <= rx_skip_d;
			avs_waitrequest <= ~(req & avs_waitrequest);
			if (rd_cap)
				avs_readdata <= rd_mux;
			irq <= irq_d;
			pci_irq_line_n <= ~irq_d;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	chk_mode_load_value: assert property (
		mode_write |=> count_q == RTM_TIMER_W'(ctrl_q[RTM_PERIOD_LSB +: RTM_PERIOD_W]) * 12'h080)
		else $error("timer not loaded with period times 128 on mode write");

	chk_mode_off_idle: assert property (
		(masking_mode_field == RTM_MODE_OFF) && !wr_ctrl && count_q == '0 |=> count_q == '0)
		else $error("timer loaded in mode 00");

	chk_tick_step_down: assert property (
		tick && !timer_load && timer_active |=> count_q == $past(count_q) - 12'h001)
		else $error("timer did not drop by exactly one on tick");

	chk_hold_while_active: assert property (
		timer_active && !rx_skip_q && !err_pass |=> !irq && pci_irq_line_n)
		else $error("line raised during masking period");

	chk_error_not_held: assert property (
		err_pass |=> irq && !pci_irq_line_n)
		else $error("error interrupt held back by timer");

	chk_status_still_set: assert property (
		receive_done_irq || transmit_done_irq |=> stat_q[RTM_ST_RX] || stat_q[RTM_ST_TX])
		else $error("status bit not set during masking");

	chk_high_prio_skip: assert property (
		hp_hit && mask_q[RTM_ST_RX] && !wr_stat && !wr_mask ##1 !wr_stat && !wr_mask |=> irq)
		else $error("high priority frame did not skip masking");

	chk_short_skip: assert property (
		short_hit && mask_q[RTM_ST_RX] && !wr_stat && !wr_mask ##1 !wr_stat && !wr_mask |=> irq)
		else $error("short frame did not skip masking");

	chk_clear_reload: assert property (
		auto_on_clear && !mode_write |=> count_q == $past(load_value))
		else $error("mode 10 did not restart after both cleared");

	chk_event_reload: assert property (
		auto_on_event && !mode_write |=> count_q == $past(load_value))
		else $error("mode 11 did not restart on new interrupt");

	chk_reserved_zero: assert property (
		rd_cap && sel_ctrl |=> avs_readdata[RTM_RSVD_BIT] == 1'b0)
		else $error("reserved control bit read as one");

	chk_bus_answer: assert property (
		req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("waitrequest did not drop for exactly one cycle");

	// Bus side: an idle slave keeps the master waiting, read data stands until the next read
	chk_idle_wait_high: assert property (
		!req && avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest dropped with no request");

	chk_read_capture: assert property (
		rd_cap |=> avs_readdata == $past(rd_mux))
		else $error("read data not loaded from the selected register");

	chk_read_holds: assert property (
		!rd_cap |=> $stable(avs_readdata))
		else $error("read data changed without a read");

	chk_reserved_never_set: assert property (
		ctrl_q[RTM_RSVD_BIT] == 1'b0)
		else $error("reserved control bit stored");

	chk_full_ctrl_write: assert property (
		wr_ctrl && avs_byteenable == 4'hF |=> ctrl_q == ($past(avs_writedata) & RTM_CTRL_WR_MASK))
		else $error("control write did not store the writable fields");

	// Status side: software clears by writing ones, but a new event always sticks
	chk_clear_by_one: assert property (
		wr_stat && set_ev == 3'h0 |=> (stat_q & $past(clr)) == 3'h0)
		else $error("status bit not cleared by writing one");

	chk_event_sets: assert property (
		set_ev != 3'h0 |=> (stat_q & $past(set_ev)) == $past(set_ev))
		else $error("event did not set its status bit");

	chk_line_inverse: assert property (
		pci_irq_line_n == !irq)
		else $error("line pin is not the inverse of irq");

	chk_irq_has_source: assert property (
		irq |-> $past(pend != 3'h0))
		else $error("irq raised with no enabled status");

	// Timer side
	chk_tx_free_at_zero: assert property (
		!timer_active && pend[RTM_ST_TX] |=> irq)
		else $error("transmit status held with timer at zero");

	chk_rx_free_at_zero: assert property (
		!timer_active && pend[RTM_ST_RX] |=> irq)
		else $error("receive status held with timer at zero");

	chk_stop_at_zero: assert property (
		!timer_active && !timer_load |=> !timer_active)
		else $error("timer moved past terminal count");

	chk_hold_no_tick: assert property (
		!tick && !timer_load |=> $stable(count_q))
		else $error("timer changed without a tick or load");

	chk_off_write_keeps: assert property (
		wr_ctrl && avs_writedata[RTM_MODE_LSB +: 2] == 2'b00 && !tick &&
		masking_mode_field == RTM_MODE_OFF |=> $stable(count_q))
		else $error("mode 00 write loaded the timer");

	chk_zero_period: assert property (
		mode_write && avs_writedata[RTM_PERIOD_LSB +: RTM_PERIOD_W] == 5'h00 |=> !timer_active)
		else $error("period zero started a masking period");

	// Receive skip marking
	chk_long_no_skip: assert property (
		receive_done_irq && rx_frame_len > 16'h0200 && !(rx_high_prio && hp_skip) &&
		!rx_skip_q |=> !rx_skip_q)
		else $error("frame above the largest limit marked short");

	chk_small_skips: assert property (
		receive_done_irq && rx_frame_len <= 16'h0040 && short_frame_skip && timer_active
		|=> rx_skip_q)
		else $error("64 byte frame not marked for skip");

	chk_skip_off_same: assert property (
		receive_done_irq && !short_frame_skip && !hp_skip && !rx_skip_q |=> !rx_skip_q)
		else $error("frame skipped masking with both skips off");

	chk_idle_no_skip: assert property (
		receive_done_irq && !timer_active && !hp_skip && !rx_skip_q |=> !rx_skip_q)
		else $error("short skip marked with timer idle");
endmodule
`default_nettype wire

// ---- rtm_mask_timer.sv ----
// Down-counting interrupt masking timer
`timescale 1ns/10ps
`default_nettype none
module rtm_mask_timer
	import rtm_pkg::*;
#(
	parameter int W = RTM_TIMER_W
)
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic load,
	input wire logic [W-1:0] load_value,
	input wire logic tick,
	output logic [W-1:0] count_q
);
	generate
		if (W < 12)
		begin : g_bad_w
			$error("rtm_mask_timer: width too small for the load value");
		end
	endgenerate

	logic [W-1:0] count_d;

	always_comb
	begin
		count_d = count_q;
		if (load)
			count_d = load_value;
		else if (tick && count_q != '0)
			count_d = count_q - W'(1);
	end

	always_ff @(posedge clk_sys)
	begin
		if (srst)
			count_q <= '0;
		else
			count_q <= count_d;
	end
endmodule
`default_nettype wire

// ---- rtm_pkg.sv ----
// Constants and types shared by the interrupt masking timer block
package rtm_pkg;
	// Register byte offsets
	localparam logic [3:0] RTM_CTRL_OFS = 4'h0;
	localparam logic [3:0] RTM_STAT_OFS = 4'h4;
	localparam logic [3:0] RTM_MASK_OFS = 4'h8;
	localparam logic [3:0] RTM_COUNT_OFS = 4'hC;
	// Control field positions
	localparam int RTM_HP_SKIP_BIT = 12;
	localparam int RTM_SCALE_BIT = 11;
	localparam int RTM_SIZE_LSB = 9;
	localparam int RTM_SHORT_SKIP_BIT = 8;
	localparam int RTM_RSVD_BIT = 7;
	localparam int RTM_MODE_LSB = 5;
	localparam int RTM_PERIOD_LSB = 0;
	localparam int RTM_PERIOD_W = 5;
	localparam logic [31:0] RTM_CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] RTM_CTRL_WR_MASK = 32'h0000_1F7F;
	// Status and mask bit positions
	localparam int RTM_ST_RX = 0;
	localparam int RTM_ST_TX = 1;
	localparam int RTM_ST_ERR = 2;
	localparam int RTM_ST_W = 3;
	localparam logic [2:0] RTM_STAT_RESET = 3'h0;
	localparam logic [2:0] RTM_MASK_RESET = 3'h0;
	// Tick derivation and masking timer
	localparam int RTM_TICK_DIV_SCALED = 20;
	localparam int RTM_TICK_DIV_PLAIN = 2;
	localparam int RTM_PERIOD_MULT = 128;
	localparam int RTM_TIMER_W = 12;
	localparam logic [15:0] RTM_SHORT_LIMIT [4] = '{16'h0040, 16'h0080, 16'h0100, 16'h0200};
	typedef enum logic [1:0] {
		RTM_MODE_OFF,
		RTM_MODE_ONCE,
		RTM_MODE_ON_CLEAR,
		RTM_MODE_ON_EVENT
	} rtm_mode_type;
endpackage

// ---- rtm_tick_gen.sv ----
// Tick pulse derived from the transmit line clock pin
`timescale 1ns/10ps
`default_nettype none
module rtm_tick_gen
	import rtm_pkg::*;
#(
	parameter int DIV_SCALED = RTM_TICK_DIV_SCALED,
	parameter int DIV_PLAIN = RTM_TICK_DIV_PLAIN
)
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic transmit_line_clock,
	input wire logic tick_scale_by_ten,
	output logic tick_q
);
	generate
		if (DIV_SCALED < 1 || DIV_SCALED > 32 || DIV_PLAIN < 1 || DIV_PLAIN > 32)
		begin : g_bad_div
			$error("rtm_tick_gen: divide ratios must be 1 to 32");
		end
	endgenerate

	logic sync1_q, sync2_q, sync3_q, level_q;
	logic [4:0] cnt_q, cnt_d;
	wire logic stable = (sync2_q == sync3_q);
	wire logic rise = stable & sync2_q & ~level_q;
	// Line clock must stay at or below a quarter of clk_sys, each level seen on two samples, for edges to be seen
	wire logic [4:0] limit = tick_scale_by_ten ? 5'(DIV_SCALED - 1) : 5'(DIV_PLAIN - 1);
	// Scale change may leave the count past the new limit, so compare with >=
	wire logic wrap = rise & (cnt_q >= limit);

	always_comb
	begin
		cnt_d = cnt_q;
		if (wrap)
			cnt_d = 5'h0;
		else if (rise)
			cnt_d = cnt_q + 5'h1;
	end

	always_ff @(posedge clk_sys)
	begin
		sync1_q <= transmit_line_clock;
		sync2_q <= sync1_q;
		sync3_q <= sync2_q;
		if (srst)
		begin
			level_q <= 1'b0;
			cnt_q <= 5'h0;
			tick_q <= 1'b0;
		end
		else
		begin
			if (stable)
				level_q <= sync2_q;
			cnt_q <= cnt_d;
			tick_q <= wrap;
		end
	end
endmodule
`default_nettype wire

// ---- tb_rtm_irq_mask.sv ----
// Self-checking bench for the interrupt masking timer block
`timescale 1ns/10ps
`default_nettype none
module tb_rtm_irq_mask import rtm_pkg::*;;
	localparam logic [31:0] ONE = 32'h0000_0001;
	logic clk_sys, srst, avs_read, avs_write, avs_waitrequest, irq, pci_irq_line_n;
	logic rx_in, tx_in, err_in, hp_in, line_clk;
	logic [3:0] avs_address, avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [15:0] len_in;
	logic [7:0] edges;
	int n_fail, n_tests, cyc;

	rtm_irq_mask rtm_irq_mask_i (.clk_sys(clk_sys), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .transmit_line_clock(line_clk),
		.receive_done_irq(rx_in), .rx_frame_len(len_in), .rx_high_prio(hp_in),
		.transmit_done_irq(tx_in), .error_irq(err_in), .irq(irq),
		.pci_irq_line_n(pci_irq_line_n));
	rtm_host_model rtm_host_model_i (.pci_irq_line_n(pci_irq_line_n),
		.transmit_line_clock(line_clk), .irq_edges(edges));

	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Whole run is about 14300 cycles; the ceiling leaves room
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			n_fail++;
			tally_and_finish;
		end
	end

	task automatic tally_and_finish;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Waits as long as the slave asks; only the bench timeout ends a hang
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= ~wr;
		do
			@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	// k holds error, transmit and receive pulses from bit 2 down
	task automatic ev(input logic [2:0] k, input logic [15:0] len, input logic h);
		@(posedge clk_sys);
		{err_in, tx_in, rx_in} <= k;
		len_in <= len;
		hp_in <= h;
		@(posedge clk_sys);
		{err_in, tx_in, rx_in} <= 3'h0;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	// Look after the edge has settled, never in the edge's own time step
	task automatic chk_irq(input logic e);
		#1;
		chk(32'({irq, pci_irq_line_n}), 32'({e, ~e}));
	endtask

	task automatic cnt(input logic [31:0] lo, input logic [31:0] hi);
		bus(1'b0, RTM_COUNT_OFS, 32'h0000_0000);
		chk(32'(rd >= lo && rd <= hi), ONE);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic clr(input logic [31:0] v);
		bus(1'b1, RTM_STAT_OFS, v);
		idle(2);
	endtask

	task automatic t_reset;
		logic [3:0] ofs [5] = '{RTM_CTRL_OFS, RTM_STAT_OFS, RTM_MASK_OFS, RTM_COUNT_OFS, 4'h1};
		foreach (ofs[i])
		begin
			bus(1'b0, ofs[i], 32'h0000_0000);
			chk(rd, 32'h0000_0000);
		end
		bus(1'b1, RTM_CTRL_OFS, 32'h0000_0005);
		cnt(32'h0000_0000, 32'h0000_0000);
		bus(1'b1, 4'h1, 32'hFFFF_FFFF);
		bus(1'b0, RTM_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0005);
		// Lane 1 only: upper control fields change, mode and period stay
		avs_byteenable <= 4'h2;
		bus(1'b1, RTM_CTRL_OFS, 32'h0000_FFFF);
		avs_byteenable <= 4'hF;
		bus(1'b0, RTM_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_1F05);
		cnt(32'h0000_0000, 32'h0000_0000);
	endtask

	task automatic t_gate;
		bus(1'b1, RTM_CTRL_OFS, 32'h0000_0021);
		cnt(32'h0000_007F, 32'h0000_0080);
		ev(3'h4, 16'h0000, 1'b0);
		chk_irq(1'b0);
		bus(1'b1, RTM_MASK_OFS, 32'h0000_0007);
		idle(2);
		chk_irq(1'b1);
		clr(32'h0000_0004);
		ev(3'h2, 16'h0000, 1'b0);
		bus(1'b0, RTM_STAT_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0002);
		chk_irq(1'b0);
		idle(880);
		cnt(ONE, 32'h0000_0080);
		idle(260);
		cnt(32'h0000_0000, 32'h0000_0000);
		chk_irq(1'b1);
		clr(32'h0000_0002);
	endtask

	task automatic t_short;
		logic [15:0] lim;
		for (int c = 0; c < 4; c++)
		begin
			bus(1'b1, RTM_CTRL_OFS, 32'h0000_0121 | (32'(c) << 9));
			lim = 16'h0040 << c;
			ev(3'h1, lim, 1'b0);
			chk_irq(1'b1);
			clr(ONE);
			ev(3'h1, lim + 16'h0001, 1'b0);
			chk_irq(1'b0);
			clr(ONE);
		end
		bus(1'b1, RTM_CTRL_OFS, 32'h0000_0021);
		ev(3'h1, 16'h0010, 1'b1);
		chk_irq(1'b0);
		clr(ONE);
		bus(1'b1, RTM_CTRL_OFS, 32'h0000_1021);
		ev(3'h1, 16'h05DC, 1'b1);
		chk_irq(1'b1);
		clr(ONE);
	endtask

	task automatic t_modes;
		bus(1'b1, RTM_CTRL_OFS, 32'h0000_0041);
		idle(1100);
		ev(3'h2, 16'h0000, 1'b0);
		chk_irq(1'b1);
		clr(32'h0000_0002);
		cnt(32'h0000_0078, 32'h0000_0080);
		bus(1'b1, RTM_CTRL_OFS, 32'h0000_0061);
		idle(1100);
		cnt(32'h0000_0000, 32'h0000_0000);
		ev(3'h2, 16'h0000, 1'b0);
		chk_irq(1'b0);
		cnt(32'h0000_0078, 32'h0000_0080);
		clr(32'h0000_0002);
	endtask

	task automatic t_scale;
		// Divide by 20 suits the 25 MHz line clock of the host model
		bus(1'b1, RTM_CTRL_OFS, 32'h0000_0821);
		idle(9400);
		cnt(ONE, 32'h0000_0080);
		idle(1300);
		cnt(32'h0000_0000, 32'h0000_0000);
		bus(1'b1, RTM_CTRL_OFS, 32'hFFFF_FFFF);
		bus(1'b0, RTM_CTRL_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_1F7F);
		cnt(32'h0000_0F7F, 32'h0000_0F80);
	endtask

	task automatic t_rerun;
		bus(1'b1, RTM_CTRL_OFS, 32'h0000_0020);
		cnt(32'h0000_0000, 32'h0000_0000);
		ev(3'h2, 16'h0000, 1'b0);
		chk_irq(1'b1);
		@(posedge clk_sys);
		srst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk(32'({avs_waitrequest, irq, pci_irq_line_n}), 32'h0000_0005);
		bus(1'b0, RTM_STAT_OFS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		cnt(32'h0000_0000, 32'h0000_0000);
	endtask

	initial
	begin
		srst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'hF;
		{err_in, tx_in, rx_in, hp_in} = 4'h0;
		len_in = 16'h0000;
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		t_reset;
		t_gate;
		t_short;
		t_modes;
		t_scale;
		t_rerun;
		chk(32'(edges != 8'h00), ONE);
		tally_and_finish;
	end
endmodule
`default_nettype wire
